// *** logic/pwmorl_top.sv ***
// Functional notes
// - Continuous slave waits for first master match
// - Later master matches reload timer with one
// - Slave period event before match clears timer
// - Switch to independent keeps running offset
// - Center mode: direction bit picks match slope
// - Direction bit ignored outside center mode
// - Direction bit buffered, moves on armed load
// - Four counts and direction load together
// - Immediate reload at first period after arming
// - Triggered reload: peer event, then period
// - Completed transfer clears load-armed bit
// - Arming during period match waits next period
// - Timer halts in sleep on system clock
// - Match flags set on rising event edge
// - Enable bits gate flags onto interrupt request
// - Flags held clear while module disabled
// - Control: enable bit7, state bit5, polarity bit4
// - Waveform mode field decodes four modes
// - Unimplemented bits read as zero
// - Offset mode field decodes four modes
// - Trigger select picks peer load event
// - Independent: run while enabled, period clears
`timescale 1ns/1ps
module pwmorl_top import pwmorl_pkg::*; (
   // APB slave
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Events from peer modules, levels synchronous to pclk
   input wire logic [2:0] offset_match_in,
   input wire logic [2:0] load_trig_in,
   // Power state
   input wire logic sleep_in,
   // Waveform and events to peers and the processor
   output logic pwm_out,
   output logic offset_match_event,
   output logic load_event_out,
   output logic irq_req
);

   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      logic en; // Module enable
      logic active_low_sel; // Active-low output select
      logic [1:0] mode; // Waveform mode
      logic out; // Raw output state
      logic [3:0] irq_en; // Interrupt enables
      logic [3:0] flags; // Match flags
      logic [1:0] offset_mode_sel; // Offset mode select
      logic [1:0] ofs; // Master offset source
      logic load_armed; // Load armed
      logic load_on_trigger; // Load on trigger
      logic [1:0] load_trigger_sel; // Load trigger source
      logic [1:0] cs; // Clock source select
      logic arm_live; // Arming old enough to act on
      logic trig_seen; // Peer load trigger caught
      pwmorl_st_e st; // Timer run state
      logic [15:0] timer; // Wave timer
      logic count_up; // Direction in center mode
      logic [31:0] prdata; // Bus read data
      logic pready; // Bus ready
      logic pslverr; // Bus error
      logic pwm_out; // Pin level
      logic ofs_out; // Offset event to slaves
      logic ld_out; // Load event to peers
      logic irq; // Interrupt request
   } pwmorl_s;

   pwmorl_s q, d;

   // ************************************************************
   // Helper functions
   // ************************************************************
   // Pick one of three peer events; code three selects nothing
   function automatic logic pick3(input logic [2:0] v, input logic [1:0] s);
      pick3 = (s == SRC_NONE) ? 1'b0 : v[s];
   endfunction

   // Address compare, used by the read mux and the write decode
   function automatic logic at(input logic [7:0] a, input logic [7:0] off);
      at = (a == off);
   endfunction

   // ************************************************************
   // Submodules and combinational helpers
   // ************************************************************
   logic [3:0] cnt_we; // Count buffer writes
   logic dir_we; // Direction buffer write
   logic load_now; // Buffer transfer strobe
   logic [3:0][15:0] cnt_shadow; // Buffered counts
   logic [3:0][15:0] cnt_op; // Operating counts
   logic dir_shadow; // Buffered direction
   logic dir_op; // Operating direction
   logic [3:0] match_lv; // Match levels while running
   logic [3:0] match_rise; // Match rising edges
   logic [5:0] ext_rise; // Peer event rising edges
   logic bus_wr; // Write taken this edge
   logic setup; // Setup phase of a transfer
   logic hit; // Mapped address
   logic tick; // Timer may advance
   logic center; // Center-aligned mode
   logic m_per; // Timer at period
   logic m_dc; // Timer at duty
   logic m_ph; // Timer at phase
   logic m_of; // Offset match, slope qualified
   logic master_ev; // Selected master offset match
   logic peer_ld; // Selected peer load event
   logic per_ev; // Period event this cycle
   logic load_ok; // Armed transfer completes
   logic [15:0] ctr_hi; // Center-mode rising match value

   pwmorl_shadow u_shadow (
      .pclk(pclk),
      .presetn(presetn),
      .cnt_we(cnt_we),
      .cnt_wdata(pwdata[15:0]),
      .dir_we(dir_we),
      .dir_wdata(pwdata[OFS_DIR_BIT]),
      .load(load_now),
      .cnt_shadow(cnt_shadow),
      .dir_shadow(dir_shadow),
      .cnt_op(cnt_op),
      .dir_op(dir_op)
   );

   pwmorl_rise #(.W(4)) u_match_rise (
      .pclk(pclk),
      .presetn(presetn),
      .level(match_lv),
      .rise(match_rise)
   );

   pwmorl_rise #(.W(6)) u_ext_rise (
      .pclk(pclk),
      .presetn(presetn),
      .level({load_trig_in, offset_match_in}),
      .rise(ext_rise)
   );

   assign setup = psel && !penable;
   assign bus_wr = psel && penable && pwrite && q.pready;
   assign hit = at(paddr, ADDR_WAVE_CTRL) || at(paddr, ADDR_IRQ_EN) ||
      at(paddr, ADDR_IRQ_FLAG) || at(paddr, ADDR_OFS_CFG) ||
      at(paddr, ADDR_RELOAD_CFG) || at(paddr, ADDR_CLK_SEL) ||
      at(paddr, ADDR_PHASE) || at(paddr, ADDR_DUTY) ||
      at(paddr, ADDR_PERIOD) || at(paddr, ADDR_OFFSET);
   assign cnt_we[CNT_PH] = bus_wr && at(paddr, ADDR_PHASE);
   assign cnt_we[CNT_DC] = bus_wr && at(paddr, ADDR_DUTY);
   assign cnt_we[CNT_PR] = bus_wr && at(paddr, ADDR_PERIOD);
   assign cnt_we[CNT_OF] = bus_wr && at(paddr, ADDR_OFFSET);
   assign dir_we = bus_wr && at(paddr, ADDR_OFS_CFG);

   // System clock as source stops in sleep; oscillators keep going
   assign tick = !(sleep_in && q.cs == CS_SYS);
   assign center = (q.mode == MODE_CTR);
   assign m_per = (q.timer == cnt_op[CNT_PR]);
   assign m_dc = (q.timer == cnt_op[CNT_DC]);
   assign m_ph = (q.timer == cnt_op[CNT_PH]);
   // Clear bit fires on the rising slope, set on the falling one
   assign m_of = (q.timer == cnt_op[CNT_OF]) &&
      (!center || (q.count_up == !dir_op));
   assign ctr_hi = cnt_op[CNT_PR] - cnt_op[CNT_DC];
   assign match_lv = (q.st == ST_RUN) ? {m_of, m_ph, m_dc, m_per} : 4'h0;
   assign master_ev = pick3(ext_rise[2:0], q.ofs);
   assign peer_ld = pick3(ext_rise[5:3], q.load_trigger_sel);
   // Center mode takes its period event at the top of the count
   assign per_ev = (q.st == ST_RUN) && tick && m_per && (!center || q.count_up);
   // Arming must be a cycle old, so one set on the match cycle waits
   assign load_ok = per_ev && q.load_armed && q.arm_live &&
      (!q.load_on_trigger || q.trig_seen);
   // Idle module takes buffer writes straight through
   assign load_now = load_ok || !q.en;

   // ************************************************************
   // Next-state logic
   // ************************************************************
   always_comb begin
      d = q;

      // Bus answer: data latched in setup, ready in the access phase
      d.pready = setup;
      d.pslverr = setup && !hit;
      d.prdata = 32'h0000_0000;
      if (setup) begin
         if (at(paddr, ADDR_WAVE_CTRL)) begin
            // Unimplemented bits stay zero in every read below
            d.prdata[CTRL_EN_BIT] = q.en;
            d.prdata[CTRL_OUT_BIT] = q.out;
            d.prdata[CTRL_POL_BIT] = q.active_low_sel;
            d.prdata[CTRL_MODE_LSB +: 2] = q.mode;
         end else if (at(paddr, ADDR_IRQ_EN)) begin
            d.prdata[3:0] = q.irq_en;
         end else if (at(paddr, ADDR_IRQ_FLAG)) begin
            d.prdata[3:0] = q.flags;
         end else if (at(paddr, ADDR_OFS_CFG)) begin
            d.prdata[OFS_MODE_LSB +: 2] = q.offset_mode_sel;
            d.prdata[OFS_DIR_BIT] = dir_shadow;
            d.prdata[OFS_SRC_LSB +: 2] = q.ofs;
         end else if (at(paddr, ADDR_RELOAD_CFG)) begin
            d.prdata[LD_ARM_BIT] = q.load_armed;
            d.prdata[LD_TRIG_BIT] = q.load_on_trigger;
            d.prdata[LD_SRC_LSB +: 2] = q.load_trigger_sel;
         end else if (at(paddr, ADDR_CLK_SEL)) begin
            d.prdata[CLK_SEL_LSB +: 2] = q.cs;
         end else if (at(paddr, ADDR_PHASE)) begin
            d.prdata[15:0] = cnt_shadow[CNT_PH];
         end else if (at(paddr, ADDR_DUTY)) begin
            d.prdata[15:0] = cnt_shadow[CNT_DC];
         end else if (at(paddr, ADDR_PERIOD)) begin
            d.prdata[15:0] = cnt_shadow[CNT_PR];
         end else if (at(paddr, ADDR_OFFSET)) begin
            d.prdata[15:0] = cnt_shadow[CNT_OF];
         end else begin
            // Unmapped: zero data, error flagged
            d.prdata = 32'h0000_0000;
         end
      end

      // Register writes
      if (bus_wr) begin
         if (at(paddr, ADDR_WAVE_CTRL)) begin
            d.en = pwdata[CTRL_EN_BIT];
            d.active_low_sel = pwdata[CTRL_POL_BIT];
            d.mode = pwdata[CTRL_MODE_LSB +: 2];
         end
         if (at(paddr, ADDR_IRQ_EN)) begin
            d.irq_en = pwdata[3:0];
         end
         if (at(paddr, ADDR_OFS_CFG)) begin
            d.offset_mode_sel = pwdata[OFS_MODE_LSB +: 2];
            d.ofs = pwdata[OFS_SRC_LSB +: 2];
         end
         if (at(paddr, ADDR_RELOAD_CFG)) begin
            d.load_on_trigger = pwdata[LD_TRIG_BIT];
            d.load_trigger_sel = pwdata[LD_SRC_LSB +: 2];
         end
         if (at(paddr, ADDR_CLK_SEL)) begin
            d.cs = pwdata[CLK_SEL_LSB +: 2];
         end
      end

      // Reload arming; hardware clear first so a fresh write survives
      d.arm_live = q.load_armed;
      if (q.load_on_trigger && q.load_armed && peer_ld) begin
         d.trig_seen = 1'b1;
      end
      if (!q.load_armed) begin
         d.trig_seen = 1'b0;
      end
      if (load_ok) begin
         d.load_armed = 1'b0;
         d.arm_live = 1'b0;
         d.trig_seen = 1'b0;
      end
      if (bus_wr && at(paddr, ADDR_RELOAD_CFG)) begin
         d.load_armed = pwdata[LD_ARM_BIT];
         d.arm_live = 1'b0;
      end

      // Timer and offset-mode state machine
      if (!q.en) begin
         d.st = ST_OFF;
         d.timer = CNT_RESET;
         d.count_up = 1'b1;
      end else begin
         case (q.st)
            ST_OFF: begin
               // Slaves hold the timer until their master fires
               d.st = (q.offset_mode_sel == OFM_IND) ? ST_RUN : ST_WAIT;
            end
            ST_WAIT: begin
               if (q.offset_mode_sel == OFM_IND || master_ev) begin
                  d.st = ST_RUN;
               end
            end
            ST_RUN: begin
               if (!tick) begin
                  d.timer = q.timer;
               end else if (q.offset_mode_sel == OFM_CONT && master_ev) begin
                  d.timer = TMR_RELOAD;
                  d.count_up = 1'b1;
               end else if (center) begin
                  if (q.count_up && m_per) begin
                     d.count_up = 1'b0;
                     d.timer = (q.timer == CNT_RESET) ? q.timer : q.timer - 16'h0001;
                  end else if (!q.count_up && q.timer == CNT_RESET) begin
                     d.count_up = 1'b1;
                     d.timer = q.timer + 16'h0001;
                  end else begin
                     d.timer = q.count_up ? q.timer + 16'h0001 : q.timer - 16'h0001;
                  end
               end else if (m_per) begin
                  // Period clears the count; a mode change keeps phase
                  d.timer = CNT_RESET;
                  if (q.offset_mode_sel == OFM_ONE) begin
                     d.st = ST_WAIT;
                  end
               end else begin
                  d.timer = q.timer + 16'h0001;
               end
            end
            default: begin
               d.st = ST_OFF;
            end
         endcase
      end

      // Output state by waveform mode; duty match wins over a same-cycle phase match
      if (!q.en) begin
         d.out = 1'b0;
      end else if (q.st == ST_RUN && tick) begin
         case (q.mode)
            MODE_STD: begin
               if (m_dc) begin
                  d.out = 1'b0;
               end else if (m_ph) begin
                  d.out = 1'b1;
               end
            end
            MODE_SET: begin
               if (m_ph) begin
                  d.out = 1'b1;
               end
            end
            MODE_TOG: begin
               if (m_per) begin
                  d.out = !q.out;
               end
            end
            MODE_CTR: begin
               if (q.count_up && q.timer == ctr_hi) begin
                  d.out = 1'b1;
               end else if (!q.count_up && q.timer == ctr_hi + 16'h0001) begin
                  d.out = 1'b0;
               end
            end
            default: begin
               d.out = q.out;
            end
         endcase
      end
      // Software may drive the state only in set-on-match mode
      if (bus_wr && at(paddr, ADDR_WAVE_CTRL) && q.mode == MODE_SET) begin
         d.out = pwdata[CTRL_OUT_BIT];
      end

      // Flags: events win over a same-cycle software write
      if (bus_wr && at(paddr, ADDR_IRQ_FLAG)) begin
         d.flags = pwdata[3:0];
      end
      d.flags = d.flags | match_rise;
      if (!q.en) begin
         d.flags = 4'h0;
      end

      // Registered outputs
      d.irq = |(d.flags & q.irq_en);
      d.pwm_out = d.out ^ q.active_low_sel;
      d.ofs_out = match_rise[FLAG_OFS];
      d.ld_out = load_ok;
   end

   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign prdata = q.prdata;
   assign pready = q.pready;
   assign pslverr = q.pslverr;
   assign pwm_out = q.pwm_out;
   assign offset_match_event = q.ofs_out;
   assign load_event_out = q.ld_out;
   assign irq_req = q.irq;

endmodule

// *** shared/pwmorl_pkg.sv ***
package pwmorl_pkg;

   // ************************************************************
   // Register map, byte addresses on the APB side
   // ************************************************************
   localparam logic [7:0] ADDR_WAVE_CTRL = 8'h00;
   localparam logic [7:0] ADDR_IRQ_EN = 8'h04;
   localparam logic [7:0] ADDR_IRQ_FLAG = 8'h08;
   localparam logic [7:0] ADDR_OFS_CFG = 8'h0c;
   localparam logic [7:0] ADDR_RELOAD_CFG = 8'h10;
   localparam logic [7:0] ADDR_CLK_SEL = 8'h14;
   localparam logic [7:0] ADDR_PHASE = 8'h18;
   localparam logic [7:0] ADDR_DUTY = 8'h1c;
   localparam logic [7:0] ADDR_PERIOD = 8'h20;
   localparam logic [7:0] ADDR_OFFSET = 8'h24;

   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int CTRL_EN_BIT = 7;
   localparam int CTRL_OUT_BIT = 5;
   localparam int CTRL_POL_BIT = 4;
   localparam int CTRL_MODE_LSB = 2;
   localparam int OFS_MODE_LSB = 5;
   localparam int OFS_DIR_BIT = 4;
   localparam int OFS_SRC_LSB = 0;
   localparam int LD_ARM_BIT = 7;
   localparam int LD_TRIG_BIT = 6;
   localparam int LD_SRC_LSB = 0;
   localparam int CLK_SEL_LSB = 0;
   localparam int FLAG_OFS = 3;
   localparam int FLAG_PH = 2;
   localparam int FLAG_DC = 1;
   localparam int FLAG_PR = 0;

   // ************************************************************
   // Count slots in the shadow memory
   // ************************************************************
   localparam int CNT_PH = 0;
   localparam int CNT_DC = 1;
   localparam int CNT_PR = 2;
   localparam int CNT_OF = 3;

   // ************************************************************
   // Encodings and reset values
   // ************************************************************
   localparam logic [1:0] MODE_STD = 2'h0;
   localparam logic [1:0] MODE_SET = 2'h1;
   localparam logic [1:0] MODE_TOG = 2'h2;
   localparam logic [1:0] MODE_CTR = 2'h3;
   localparam logic [1:0] OFM_IND = 2'h0;
   localparam logic [1:0] OFM_SYNC = 2'h1;
   localparam logic [1:0] OFM_ONE = 2'h2;
   localparam logic [1:0] OFM_CONT = 2'h3;
   localparam logic [1:0] SRC_NONE = 2'h3;
   localparam logic [1:0] CS_SYS = 2'h0;
   localparam logic [15:0] TMR_RELOAD = 16'h0001;
   localparam logic [15:0] CNT_RESET = 16'h0000;
   localparam logic [7:0] REG_RESET = 8'h00;

   // Offset-mode timer states
   typedef enum logic [1:0] {
      ST_OFF = 2'b00,
      ST_WAIT = 2'b01,
      ST_RUN = 2'b10
   } pwmorl_st_e;

endpackage

// *** logic/pwmorl_rise.sv ***
`timescale 1ns/1ps
module pwmorl_rise import pwmorl_pkg::*; #(
   parameter int W = 4
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Level in, one-cycle pulse out
   input wire logic [W-1:0] level,
   output logic [W-1:0] rise
);

   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      logic [W-1:0] prev; // Level seen last cycle
   } pwmorl_rise_s;

   pwmorl_rise_s q, d;

   // Pulse only on a low-to-high step, so a held level counts once
   assign rise = level & ~q.prev;

   // Next state
   always_comb begin
      d = q;
      d.prev = level;
   end

   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

endmodule

// *** logic/pwmorl_shadow.sv ***
`timescale 1ns/1ps
module pwmorl_shadow import pwmorl_pkg::*; (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Software write side
   input wire logic [3:0] cnt_we,
   input wire logic [15:0] cnt_wdata,
   input wire logic dir_we,
   input wire logic dir_wdata,
   // Transfer strobe
   input wire logic load,
   // Buffered and operating values
   output logic [3:0][15:0] cnt_shadow,
   output logic dir_shadow,
   output logic [3:0][15:0] cnt_op,
   output logic dir_op
);

   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      logic [3:0][15:0] sh; // Software-facing buffers
      logic sh_dir; // Buffered offset direction
      logic [3:0][15:0] op; // Operating counts
      logic op_dir; // Operating offset direction
   } pwmorl_shadow_s;

   pwmorl_shadow_s q, d;

   assign cnt_shadow = q.sh;
   assign dir_shadow = q.sh_dir;
   assign cnt_op = q.op;
   assign dir_op = q.op_dir;

   // Writes land in buffers; one strobe moves all of them at once
   always_comb begin
      d = q;
      for (int i = 0; i < 4; i++) begin
         if (cnt_we[i]) begin
            d.sh[i] = cnt_wdata;
         end
      end
      if (dir_we) begin
         d.sh_dir = dir_wdata;
      end
      // Transfer uses the old buffer so a same-cycle write waits a load
      if (load) begin
         d.op = q.sh;
         d.op_dir = q.sh_dir;
      end
   end

   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

endmodule

// *** dv/pwmorl_peer.sv ***
`timescale 1ns/1ps
module pwmorl_peer (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Commands from the bench
   input wire logic [2:0] go_of,
   input wire logic [2:0] go_ld,
   // Event levels toward the block
   output logic [2:0] of_lvl,
   output logic [2:0] ld_lvl
);
   logic [2:0] of_q; // Last command, stretches the level
   logic [2:0] ld_q; // Same for load triggers
   // Peers run on pclk, never faster than the block
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         of_q <= 3'h0;
         ld_q <= 3'h0;
         of_lvl <= 3'h0;
         ld_lvl <= 3'h0;
      end else begin
         of_q <= go_of;
         ld_q <= go_ld;
         // Two-cycle level so a rise is never missed
         of_lvl <= go_of | of_q;
         ld_lvl <= go_ld | ld_q;
      end
   end
endmodule

// *** dv/pwmorl_checker.sv ***
`timescale 1ns/1ps
module pwmorl_checker import pwmorl_pkg::*; (
   // APB side
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Event and request outputs
   input wire logic offset_match_event,
   input wire logic load_event_out,
   input wire logic irq_req
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Bus steps
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_wr;
      psel && penable && pready && pwrite;
   endsequence
   a_ready_next: assert property (s_setup |=> pready) else $error("pready late");
   a_ready_single: assert property (pready |=> !pready) else $error("pready long");
   a_err_ready: assert property (pslverr |-> pready) else $error("stray pslverr");
   a_err_zero: assert property (pslverr |-> prdata == 32'h0) else $error("err data");
   a_ofs_pulse: assert property (offset_match_event |=> !offset_match_event)
      else $error("offset pulse long");
   a_load_pulse: assert property (load_event_out |=> !load_event_out)
      else $error("load pulse long");
   a_irq_masked: assert property (s_wr ##0 (paddr == ADDR_IRQ_EN && pwdata[3:0] == 4'h0)
      |-> ##2 !irq_req) else $error("irq not masked");
   a_irq_disabled: assert property (s_wr ##0 (paddr == ADDR_WAVE_CTRL && !pwdata[7])
      |-> ##3 !irq_req) else $error("irq while off");
endmodule

bind pwmorl_top pwmorl_checker u_chk (.pclk(pclk), .presetn(presetn), .paddr(paddr),
   .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .offset_match_event(offset_match_event),
   .load_event_out(load_event_out), .irq_req(irq_req));

// *** dv/tb.sv ***
`timescale 1ns/1ps
module tb import pwmorl_pkg::*;;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sleep_in;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic [2:0] of_in, ld_in, go_of, go_ld;
   logic pwm_out, ofs_ev, ld_ev, irq_req, e, f;
   int mismatches = 0;
   int checks = 0;
   int cyc = 0;
   // Clock, 50 ns period
   initial begin
      pclk = 0;
      forever #25 pclk = ~pclk;
   end
   pwmorl_peer peer (.pclk(pclk), .presetn(presetn), .go_of(go_of), .go_ld(go_ld),
      .of_lvl(of_in), .ld_lvl(ld_in));
   pwmorl_top DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .offset_match_in(of_in), .load_trig_in(ld_in), .sleep_in(sleep_in),
      .pwm_out(pwm_out), .offset_match_event(ofs_ev), .load_event_out(ld_ev),
      .irq_req(irq_req));
   // ************
   // Helpers
   // ************
   task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
      checks++;
      if (g !== x) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", n, x, g);
      end
   endtask
   // One APB transfer, held until pready
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] x, input string n);
      xfer(0, a, 0);
      chk(n, x, r);
   endtask
   // Watch for a buffer-load pulse
   task automatic wait_ld(input int n);
      f = 0;
      repeat (n) begin
         @(posedge pclk);
         if (ld_ev === 1'b1) f = 1;
      end
   endtask
   task automatic fire(input logic [2:0] o, input logic [2:0] l);
      @(posedge pclk);
      go_of <= o;
      go_ld <= l;
      @(posedge pclk);
      go_of <= 0;
      go_ld <= 0;
   endtask
   // ************
   // Scenarios
   // ************
   task automatic t_map;
      rd(ADDR_WAVE_CTRL, 0, "ctrl");
      rd(ADDR_IRQ_FLAG, 0, "flags");
      xfer(0, 8'h3c, 0);
      chk("unmapped", 1, e);
      xfer(1, ADDR_WAVE_CTRL, 32'h5f);
      rd(ADDR_WAVE_CTRL, 32'h1c, "ctrl_rb");
      chk("pol_pin", 1, pwm_out);
      chk("ctrl_bits", 32'h1c, r & ~32'h20);
      xfer(1, ADDR_IRQ_EN, 32'hff);
      rd(ADDR_IRQ_EN, 32'h0f, "en_bits");
      xfer(1, ADDR_IRQ_FLAG, 32'h0f);
      rd(ADDR_IRQ_FLAG, 0, "flags_off");
      xfer(1, ADDR_IRQ_EN, 0);
      xfer(1, ADDR_WAVE_CTRL, 0);
   endtask
   task automatic t_imm;
      xfer(1, ADDR_PERIOD, 8);
      xfer(1, ADDR_PHASE, 2);
      xfer(1, ADDR_DUTY, 4);
      xfer(1, ADDR_WAVE_CTRL, 32'h80);
      xfer(1, ADDR_PERIOD, 6);
      xfer(1, ADDR_RELOAD_CFG, 32'h80);
      wait_ld(30);
      chk("imm_load", 1, f);
      rd(ADDR_RELOAD_CFG, 0, "arm_clear");
      xfer(0, ADDR_IRQ_FLAG, 0);
      chk("period_flag", 1, r & 32'h1);
      xfer(1, ADDR_IRQ_EN, 1);
      repeat (3) @(posedge pclk);
      chk("irq", 1, irq_req);
      xfer(1, ADDR_IRQ_EN, 0);
   endtask
   task automatic t_trig;
      xfer(1, ADDR_RELOAD_CFG, 32'hc1);
      wait_ld(40);
      chk("no_trig_load", 0, f);
      rd(ADDR_RELOAD_CFG, 32'hc1, "armed");
      fire(0, 3'h2);
      wait_ld(30);
      chk("trig_load", 1, f);
      rd(ADDR_RELOAD_CFG, 32'h41, "trig_clear");
   endtask
   task automatic t_slave;
      xfer(1, ADDR_WAVE_CTRL, 0);
      xfer(1, ADDR_OFS_CFG, 32'h60);
      xfer(1, ADDR_WAVE_CTRL, 32'h80);
      repeat (30) @(posedge pclk);
      xfer(0, ADDR_IRQ_FLAG, 0);
      chk("held", 0, r & 32'h1);
      fire(3'h1, 0);
      repeat (20) @(posedge pclk);
      xfer(0, ADDR_IRQ_FLAG, 0);
      chk("started", 1, r & 32'h1);
   endtask
   // Master match every 4 cycles keeps the timer off zero and period
   task automatic t_reload;
      f = 0;
      for (int k = 0; k < 40; k++) begin
         @(posedge pclk);
         go_of <= (k % 4 == 0) ? 3'h1 : 3'h0;
         if (k > 8 && ofs_ev === 1'b1) f = 1;
      end
      chk("reload_one", 0, f);
      // Without master matches the period clears the timer again
      f = 0;
      repeat (20) begin
         @(posedge pclk);
         if (ofs_ev === 1'b1) f = 1;
      end
      chk("period_clear", 1, f);
   endtask
   // System clock source freezes the timer in sleep
   task automatic t_sleep;
      sleep_in <= 1;
      repeat (3) @(posedge pclk);
      xfer(1, ADDR_IRQ_FLAG, 0);
      repeat (20) @(posedge pclk);
      xfer(0, ADDR_IRQ_FLAG, 0);
      chk("sleep_hold", 0, r);
      sleep_in <= 0;
      repeat (20) @(posedge pclk);
      xfer(0, ADDR_IRQ_FLAG, 0);
      chk("sleep_wake", 1, r & 32'h1);
   endtask
   task automatic wrap_up;
      if (mismatches == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // Hang guard, far above the run length
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 5000) begin
         mismatches++;
         wrap_up;
      end
   end
   initial begin
      {presetn, psel, penable, pwrite, sleep_in} = 0;
      {paddr, pwdata, go_of, go_ld} = 0;
      repeat (20) @(posedge pclk);
      presetn <= 1;
      t_map;
      t_imm;
      t_trig;
      t_slave;
      t_reload;
      t_sleep;
      wrap_up;
   end
endmodule
